// file: rspi_host_model.sv
// host side serial master model for the radio port
`timescale 1ns/10ps
`default_nettype none
module rspi_host_model (
	// serial pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	// received word
	output logic [7:0] got_o,
	output logic got_stb_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b1;
		got_o = 8'h00;
		got_stb_o = 1'b0;
	end

	// one select period; sclk stands still outside it
	task automatic xfer(input logic [7:0] q[$]);
		logic [7:0] w;
		#37 cs_n_o <= 1'b0;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				mosi_o <= q[i][b];
				#80 sclk_o <= 1'b1;
				w[b] = miso_i;
				#80 sclk_o <= 1'b0;
			end
			got_o <= w;
			got_stb_o <= 1'b1;
			#1 got_stb_o <= 1'b0;
		end
		#80 cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		#200;
	endtask : xfer
endmodule : rspi_host_model
`default_nettype wire

// file: rspi_link.sv
// serial clock side: byte shifter and miso driver
`timescale 1ns/10ps
`default_nettype none
module rspi_link (
	// serial pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// core side
	input wire logic rst_n_i,
	rspi_link_if.link lk
);
	import rspi_pkg::*;
	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
	} rspi_lrx_t;
	rspi_lrx_t st_r, st_nxt;
	logic [7:0] byte_r;
	logic tgl_r;
	logic out_r;
	logic go_r;

	always_comb begin
		st_nxt = st_r;
		st_nxt.cnt = st_r.cnt + 3'h1;
		st_nxt.sh = {st_r.sh[5:0], mosi_i};
	end

	// bit count restarts with every select period
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// toggle survives select so the core sees every byte once
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_r <= 8'h00;
			tgl_r <= 1'b0;
		end else if (st_r.cnt == 3'h7) begin
			byte_r <= {st_r.sh, mosi_i};
			tgl_r <= ~tgl_r;
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			out_r <= 1'b0;
			go_r <= 1'b0;
		end else begin
			out_r <= lk.tx_word[~st_r.cnt];
			go_r <= 1'b1;
		end
	end

	assign lk.rx_byte = byte_r;
	assign lk.rx_tgl = tgl_r;
	assign miso_oe_o = ~cs_n_i;
	assign miso_o = ~cs_n_i & (go_r ? out_r : lk.tx_word[7]);
endmodule : rspi_link
`default_nettype wire

// file: rspi_link_if.sv
// bundle between the serial clock logic and the core
`timescale 1ns/10ps
`default_nettype none
interface rspi_link_if;
	logic [7:0] rx_byte;
	logic rx_tgl;
	logic [7:0] tx_word;
	modport link(output rx_byte, output rx_tgl, input tx_word);
	modport core(input rx_byte, input rx_tgl, output tx_word);
endinterface : rspi_link_if
`default_nettype wire

// file: rspi_mem.sv
// packet, config, modem control and program ram banks
`timescale 1ns/10ps
`default_nettype none
module rspi_mem (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// host port
	input wire logic hw_we_i,
	input wire logic hw_pram_i,
	input wire logic [rspi_pkg::ADDR_W-1:0] hw_addr_i,
	input wire logic [7:0] hw_wdata_i,
	output logic [7:0] hw_rdata_o,
	input wire logic mcr_clr_i,
	// modem packet port
	input wire logic md_we_i,
	input wire logic [7:0] md_addr_i,
	input wire logic [7:0] md_wdata_i,
	output logic [7:0] md_rdata_o,
	// configuration taps
	output logic [7:0] tx_base_o,
	output logic [7:0] rx_base_o,
	output logic [7:0] irq_mask_o
);
	import rspi_pkg::*;
	typedef struct packed {
		logic [MCR_BYTES-1:0] mval;
		logic [CFG_BYTES-1:0] cval;
		logic [7:0] rd;
		logic [7:0] md;
	} rspi_mem_t;
	rspi_mem_t st_r, st_nxt;
	logic [7:0] pkt_m [PKT_BYTES];
	logic [7:0] cfg_m [CFG_BYTES];
	logic [7:0] mcr_m [MCR_BYTES];
	logic [7:0] pram_m [PRAM_BYTES];
	logic in_pkt, in_cfg, in_mcr;
	logic [7:0] lo;

	assign lo = hw_addr_i[7:0];
	assign in_pkt = ~hw_pram_i & (hw_addr_i[10:8] == BANK_PKT);
	assign in_cfg = ~hw_pram_i & (hw_addr_i[10:8] == BANK_CFG)
		& (lo[7:6] == 2'b00);
	assign in_mcr = ~hw_pram_i & (hw_addr_i[10:8] == BANK_MCR);

	always_comb begin
		st_nxt = st_r;
		st_nxt.md = pkt_m[md_addr_i];
		st_nxt.rd = 8'h00;
		if (in_pkt) begin
			st_nxt.rd = pkt_m[lo];
		end else if (in_cfg && st_r.cval[lo[5:0]]) begin
			st_nxt.rd = cfg_m[lo[5:0]];
		end else if (in_mcr && st_r.mval[lo]) begin
			st_nxt.rd = mcr_m[lo];
		end
		if (mcr_clr_i) begin
			st_nxt.mval = '0;
		end else if (hw_we_i && in_mcr) begin
			st_nxt.mval[lo] = 1'b1;
		end
		// unwritten config bytes read as zero, so taps never go unknown
		if (hw_we_i && in_cfg) begin
			st_nxt.cval[lo[5:0]] = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// memories carry no reset
	always_ff @(posedge clock_i) begin
		if (hw_we_i && hw_pram_i) begin
			pram_m[hw_addr_i] <= hw_wdata_i;
		end
		if (hw_we_i && in_pkt && lo >= PKT_RSVD) begin
			pkt_m[lo] <= hw_wdata_i;
		end
		if (md_we_i && md_addr_i >= PKT_RSVD) begin
			pkt_m[md_addr_i] <= md_wdata_i;
		end
		if (hw_we_i && in_cfg) begin
			cfg_m[lo[5:0]] <= hw_wdata_i;
		end
		if (hw_we_i && in_mcr) begin
			mcr_m[lo] <= hw_wdata_i;
		end
	end

	assign hw_rdata_o = st_r.rd;
	assign md_rdata_o = st_r.md;
	assign tx_base_o = st_r.cval[TX_BASE_ADR[5:0]]
		? cfg_m[TX_BASE_ADR[5:0]] : 8'h00;
	assign rx_base_o = st_r.cval[RX_BASE_ADR[5:0]]
		? cfg_m[RX_BASE_ADR[5:0]] : 8'h00;
	assign irq_mask_o = st_r.cval[IRQ_MASK1_ADR[5:0]]
		? cfg_m[IRQ_MASK1_ADR[5:0]] : 8'h00;
endmodule : rspi_mem
`default_nettype wire

// file: rspi_pkg.sv
// constants and types of the radio serial command and status port
// Contract
// - after transmit done: amplifier ramp 3.4 us, first bit 1.5 bits + 2.3 us
// - every radio memory location has an 11-bit address
// - 256-byte modem control ram, contents lost in sleep
// - packet buffer lowest 16 bytes internal, other 240 for packets
// - receive data stored from rx pointer, transmit read from tx pointer
// - 2 kB program ram loaded over the port, 4 kB program rom
// - port inactive and miso disabled while select is high
// - eight-bit words, most significant bit first, both directions
// - mosi sampled on rising, miso shifted on falling serial clock
// - select low drives status bit 7 on miso at once
// - controller commands to controller, memory commands to separate engine
// - command executes on the last rising edge of its byte
// - one command per select-low period, except a double no-op
// - status byte returned during every byte shifted in; code returns read data instead after the first data byte of a memory read
// - status: ready bit 7, irq bit 6, queue free bit 5, state 4:0
// - state codes 0x0f init, 0x00 busy, 0x11..0x14, 0x06, 0x05, 0x07
// - one-deep queue; free drops on queued accept, rises when it starts
// - irq on queue free or command done, flagged in source register
// - no-op command byte is 0xff
package rspi_pkg;
	localparam int CLK_MHZ = 125;
	localparam int PA_RAMP_NS = 3400;
	localparam int DATA_LEAD_NS = 2300;
	localparam logic [17:0] PA_RAMP_CYC =
		18'((PA_RAMP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [17:0] DATA_LEAD_CYC =
		18'((DATA_LEAD_NS * CLK_MHZ + 999) / 1000);
	localparam int ADDR_W = 11;
	localparam int PKT_BYTES = 256;
	localparam logic [7:0] PKT_RSVD = 8'h10;
	localparam int MCR_BYTES = 256;
	localparam int CFG_BYTES = 64;
	localparam int PRAM_BYTES = 2048;
	localparam int PROM_BYTES = 4096;
	localparam logic [2:0] BANK_PKT = 3'h0;
	localparam logic [2:0] BANK_CFG = 3'h1;
	localparam logic [2:0] BANK_MCR = 3'h3;
	localparam logic [10:0] TX_BASE_ADR = 11'h124;
	localparam logic [10:0] RX_BASE_ADR = 11'h125;
	localparam logic [10:0] IRQ_MASK1_ADR = 11'h101;
	localparam logic [10:0] IRQ_SRC1_ADR = 11'h337;
	localparam logic [7:0] IRQ_SRC1_USED = 8'h43;
	localparam int IRQ_QFREE_BIT = 6;
	localparam int IRQ_PORT_BIT = 1;
	localparam int IRQ_DONE_BIT = 0;
	localparam logic [7:0] NO_OP_CMD = 8'hff;
	localparam logic [4:0] MEM_WR_OP = 5'h03;
	localparam logic [4:0] MEM_RD_OP = 5'h07;
	localparam logic [7:0] PRAM_WR_CMD = 8'h1e;
	localparam logic [3:0] CTRL_PFX = 4'hc;
	localparam logic [7:0] GO_OFF_CMD = 8'hc1;
	localparam logic [7:0] GO_IDLE_CMD = 8'hc2;
	localparam logic [7:0] GO_RX_CMD = 8'hc3;
	localparam logic [7:0] GO_TX_CMD = 8'hc4;
	localparam logic [7:0] SLEEP_CMD = 8'hc5;
	localparam logic [7:0] APPLY_CFG_CMD = 8'hc6;
	localparam logic [7:0] SIG_STR_CMD = 8'hc7;
	localparam logic [7:0] IMAGE_CAL_CMD = 8'hc8;
	localparam logic [15:0] INIT_CYC = 16'h0100;
	localparam logic [15:0] BUSY_CYC = 16'h0080;
	localparam logic [15:0] MEAS_CYC = 16'h0040;
	typedef enum logic [4:0] {
		C_BUSY = 5'h00,
		C_RSSI = 5'h05,
		C_SLEEP = 5'h06,
		C_ICAL = 5'h07,
		C_INIT = 5'h0f,
		C_OFF = 5'h11,
		C_IDLE = 5'h12,
		C_RX = 5'h13,
		C_TX = 5'h14
	} rspi_ctrl_t;
	typedef enum logic [2:0] {
		F_CMD = 3'b000,
		F_ADDR = 3'b001,
		F_WDATA = 3'b010,
		F_RDATA = 3'b011,
		F_SKIP = 3'b100
	} rspi_frm_t;
endpackage : rspi_pkg

// file: rspi_port.sv
// serial command and status port of the radio with its command queue
`timescale 1ns/10ps
`default_nettype none
module rspi_port (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// serial link
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	// radio interrupt pin
	output logic radio_irq_o,
	// transmit timing
	input wire logic [15:0] tbit_cyc_i,
	output logic pa_ramp_o,
	output logic tx_first_bit_o,
	// modem packet port
	input wire logic mdm_rx_we_i,
	input wire logic [7:0] mdm_rx_data_i,
	input wire logic mdm_tx_rd_i,
	output logic [7:0] mdm_tx_data_o,
	// controller state
	output rspi_pkg::rspi_ctrl_t ctrl_state_o
);
	import rspi_pkg::*;

	typedef struct packed {
		rspi_frm_t frm;
		logic pram;
		logic wr;
		logic [ADDR_W-1:0] addr;
		rspi_ctrl_t ctrl;
		rspi_ctrl_t tgt;
		logic [15:0] cnt;
		logic qfull;
		logic [7:0] qcmd;
		logic [7:0] src;
		logic [7:0] word;
		logic seen;
		logic txt_on;
		logic [17:0] txt;
		logic pa;
		logic fb;
		logic mclr;
		logic [7:0] rx_off;
		logic [7:0] tx_off;
	} rspi_core_t;

	rspi_core_t st_r, st_nxt;
	logic [1:0] rst_q;
	logic rst_n;
	logic [1:0] cs_q;
	logic [1:0] tg_q;
	logic cs_hi;
	logic ev;
	logic [7:0] rx_b;
	logic is_mem;
	logic is_ctrl;
	logic port_rdy;
	logic busy_st;
	logic [7:0] status;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic hw_we;
	logic [7:0] rd_b;
	logic [7:0] md_addr;
	logic [7:0] tx_base;
	logic [7:0] rx_base;
	logic [7:0] irq_mask;
	logic [17:0] lead;

	rspi_link_if lnk();

	// reset release through two flops
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// select and byte toggle cross into the core clock
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_q <= 2'b11;
			tg_q <= 2'b00;
		end else begin
			cs_q <= {cs_q[0], spi_cs_n_i};
			tg_q <= {tg_q[0], lnk.rx_tgl};
		end
	end
	assign cs_hi = cs_q[1];

	rspi_link u_link (
		.sclk_i(spi_sclk_i),
		.cs_n_i(spi_cs_n_i),
		.mosi_i(spi_mosi_i),
		.miso_o(spi_miso_o),
		.miso_oe_o(spi_miso_oe_o),
		.rst_n_i(rst_n),
		.lk(lnk.link)
	);

	rspi_mem u_mem (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.hw_we_i(hw_we),
		.hw_pram_i(st_r.pram),
		.hw_addr_i(st_r.addr),
		.hw_wdata_i(rx_b),
		.hw_rdata_o(rd_b),
		.mcr_clr_i(st_r.mclr),
		.md_we_i(mdm_rx_we_i && st_r.ctrl == C_RX),
		.md_addr_i(md_addr),
		.md_wdata_i(mdm_rx_data_i),
		.md_rdata_o(mdm_tx_data_o),
		.tx_base_o(tx_base),
		.rx_base_o(rx_base),
		.irq_mask_o(irq_mask)
	);

	// byte is stable once its toggle has been synchronised
	assign rx_b = lnk.rx_byte;
	assign ev = tg_q[1] ^ st_r.seen;
	assign is_mem = (rx_b[7:3] == MEM_WR_OP)
		| (rx_b[7:3] == MEM_RD_OP);
	assign is_ctrl = rx_b[7:4] == CTRL_PFX;
	assign port_rdy = (st_r.ctrl != C_INIT) & (st_r.ctrl != C_SLEEP);
	assign busy_st = (st_r.ctrl == C_INIT) | (st_r.ctrl == C_BUSY)
		| (st_r.ctrl == C_RSSI) | (st_r.ctrl == C_ICAL);
	assign status = {port_rdy, |st_r.src, ~st_r.qfull,
		st_r.ctrl};
	assign lead = DATA_LEAD_CYC + {2'b00, tbit_cyc_i}
		+ {3'b000, tbit_cyc_i[15:1]};
	assign md_addr = (st_r.ctrl == C_TX)
		? tx_base + st_r.tx_off
		: rx_base + st_r.rx_off;

	always_comb begin
		st_nxt = st_r;
		st_nxt.seen = tg_q[1];
		st_nxt.pa = 1'b0;
		st_nxt.fb = 1'b0;
		st_nxt.mclr = 1'b0;
		set_v = 8'h00;
		clr_v = 8'h00;
		hw_we = 1'b0;

		// radio controller and its one-deep queue
		if (st_r.ctrl == C_SLEEP) begin
			if (!cs_hi) begin
				st_nxt.ctrl = C_INIT;
				st_nxt.cnt = INIT_CYC;
				st_nxt.tgt = C_OFF;
			end
		end else if (busy_st) begin
			if (st_r.cnt == 16'h0000) begin
				st_nxt.ctrl = st_r.tgt;
				if (st_r.ctrl == C_INIT) begin
					set_v[IRQ_PORT_BIT] = 1'b1;
				end else begin
					set_v[IRQ_DONE_BIT] = 1'b1;
				end
				if (st_r.tgt == C_TX) begin
					st_nxt.txt_on = 1'b1;
					st_nxt.txt = 18'h00001;
					st_nxt.tx_off = 8'h00;
				end
				if (st_r.tgt == C_RX) begin
					st_nxt.rx_off = 8'h00;
				end
				if (st_r.tgt == C_SLEEP) begin
					st_nxt.mclr = 1'b1;
				end
			end else begin
				st_nxt.cnt = st_r.cnt - 16'h0001;
			end
		end else if (st_r.qfull) begin
			st_nxt.qfull = 1'b0;
			set_v[IRQ_QFREE_BIT] = 1'b1;
			st_nxt.ctrl = C_BUSY;
			st_nxt.cnt = BUSY_CYC;
			st_nxt.tgt = st_r.ctrl;
			case (st_r.qcmd)
				GO_OFF_CMD: st_nxt.tgt = C_OFF;
				GO_IDLE_CMD: st_nxt.tgt = C_IDLE;
				GO_RX_CMD: st_nxt.tgt = C_RX;
				GO_TX_CMD: st_nxt.tgt = C_TX;
				SLEEP_CMD: st_nxt.tgt = C_SLEEP;
				APPLY_CFG_CMD: begin
					if (st_r.ctrl != C_OFF && st_r.ctrl != C_IDLE) begin
						st_nxt.ctrl = st_r.ctrl;
					end
				end
				SIG_STR_CMD: begin
					st_nxt.ctrl = C_RSSI;
					st_nxt.cnt = MEAS_CYC;
				end
				IMAGE_CAL_CMD: st_nxt.ctrl = C_ICAL;
				default: st_nxt.ctrl = st_r.ctrl;
			endcase
		end

		// modem pointers advance per packet byte
		if (mdm_rx_we_i && st_r.ctrl == C_RX) begin
			st_nxt.rx_off = st_r.rx_off + 8'h01;
		end
		if (mdm_tx_rd_i && st_r.ctrl == C_TX) begin
			st_nxt.tx_off = st_r.tx_off + 8'h01;
		end

		// transmit start timing after the done event
		if (st_r.txt_on) begin
			st_nxt.txt = st_r.txt + 18'h00001;
			if (st_r.txt == PA_RAMP_CYC) begin
				st_nxt.pa = 1'b1;
			end
			if (st_r.txt == lead) begin
				st_nxt.fb = 1'b1;
			end
			if (st_r.txt >= PA_RAMP_CYC && st_r.txt >= lead) begin
				st_nxt.txt_on = 1'b0;
			end
		end
		if (st_r.ctrl != C_TX && st_r.ctrl != C_BUSY) begin
			st_nxt.txt_on = 1'b0;
		end

		// per select period byte handling
		if (cs_hi) begin
			st_nxt.frm = F_CMD;
			st_nxt.word = status;
		end else if (ev) begin
			st_nxt.word = status;
			case (st_r.frm)
				F_CMD: begin
					st_nxt.frm = F_SKIP;
					if (rx_b != NO_OP_CMD && is_mem && port_rdy) begin
						st_nxt.pram = rx_b == PRAM_WR_CMD;
						st_nxt.wr = rx_b[7:3] == MEM_WR_OP;
						st_nxt.addr = (rx_b == PRAM_WR_CMD)
							? {ADDR_W{1'b0}}
							: {rx_b[2:0], 8'h00};
						st_nxt.frm = F_ADDR;
					end else if (rx_b != NO_OP_CMD && is_ctrl
						&& !st_r.qfull) begin
						st_nxt.qfull = 1'b1;
						st_nxt.qcmd = rx_b;
					end
				end
				F_ADDR: begin
					st_nxt.addr[7:0] = rx_b;
					st_nxt.frm = st_r.wr ? F_WDATA : F_RDATA;
				end
				F_WDATA: begin
					if (!st_r.pram && st_r.addr == IRQ_SRC1_ADR) begin
						clr_v = rx_b;
					end else begin
						hw_we = 1'b1;
					end
					st_nxt.addr = st_r.addr + 11'h001;
				end
				F_RDATA: begin
					st_nxt.word = (st_r.addr == IRQ_SRC1_ADR)
						? st_r.src : rd_b;
					st_nxt.addr = st_r.addr + 11'h001;
				end
				default: st_nxt.frm = F_SKIP;
			endcase
		end

		// source bits: a new event wins over a clear
		st_nxt.src = ((st_r.src & ~clr_v)
			| (set_v & irq_mask)) & IRQ_SRC1_USED;
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{
				frm: F_CMD,
				ctrl: C_INIT,
				tgt: C_OFF,
				cnt: INIT_CYC,
				word: {3'b000, C_INIT},
				default: '0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lnk.tx_word = st_r.word;
	assign radio_irq_o = |st_r.src;
	assign pa_ramp_o = st_r.pa;
	assign tx_first_bit_o = st_r.fb;
	assign ctrl_state_o = st_r.ctrl;
endmodule : rspi_port
`default_nettype wire

// file: rspi_port_assertions.sv
// concurrent checks on the ports of the radio serial port
`timescale 1ns/10ps
`default_nettype none
module rspi_port_assertions
	import rspi_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// serial link
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe_o,
	// transmit timing
	input wire logic [15:0] tbit_cyc_i,
	input wire logic pa_ramp_o,
	input wire logic tx_first_bit_o,
	// controller state
	input wire rspi_ctrl_t ctrl_state_o
);
	logic [17:0] gap_r;

	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	// cycles since the last amplifier ramp pulse
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap_r <= 18'h0;
		end else if (pa_ramp_o) begin
			gap_r <= 18'h1;
		end else if (gap_r != 18'h0 && gap_r != 18'h3ffff) begin
			gap_r <= gap_r + 18'h1;
		end
	end

	oe_select_a: assert property (spi_miso_oe_o == !spi_cs_n_i)
		else $error("miso enable differs from select");
	miso_quiet_a: assert property (spi_cs_n_i |-> !spi_miso_o)
		else $error("miso high while deselected");
	state_code_a: assert property (ctrl_state_o inside {C_BUSY, C_RSSI,
		C_SLEEP, C_ICAL, C_INIT, C_OFF, C_IDLE, C_RX, C_TX})
		else $error("illegal controller state code");
	ramp_pulse_a: assert property (pa_ramp_o |=> !pa_ramp_o)
		else $error("ramp pulse longer than one cycle");
	first_bit_gap_a: assert property (tx_first_bit_o |-> gap_r ==
		DATA_LEAD_CYC + 18'(tbit_cyc_i) + 18'(tbit_cyc_i >> 1) - PA_RAMP_CYC)
		else $error("first data bit at wrong distance from ramp");
	ramp_in_tx_a: assert property (pa_ramp_o |-> ctrl_state_o == C_TX)
		else $error("ramp outside transmit state");
	busy_ends_a: assert property ($rose(ctrl_state_o == C_BUSY) |->
		(ctrl_state_o == C_BUSY) [*8] ##[1:300] ctrl_state_o != C_BUSY)
		else $error("busy state length wrong");
	init_to_off_a: assert property ($fell(ctrl_state_o == C_INIT) |->
		ctrl_state_o == C_OFF)
		else $error("initialising not followed by radio off");
endmodule : rspi_port_assertions

bind rspi_port rspi_port_assertions chk_u (
	.clock_i(clock_i),
	.reset_n_i(reset_n_i),
	.spi_cs_n_i(spi_cs_n_i),
	.spi_miso_o(spi_miso_o),
	.spi_miso_oe_o(spi_miso_oe_o),
	.tbit_cyc_i(tbit_cyc_i),
	.pa_ramp_o(pa_ramp_o),
	.tx_first_bit_o(tx_first_bit_o),
	.ctrl_state_o(ctrl_state_o)
);
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the radio serial port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rspi_pkg::*;
	localparam logic [15:0] NA = 16'h0;
	logic clock_i, reset_n_i, sclk, cs_n, mosi, miso, miso_oe, miso_w, flt;
	logic irq, ramp, first, mdm_rx_we, mdm_tx_rd, got_stb;
	logic [7:0] mdm_rx_data, mdm_tx_data, got, pkt[3];
	logic [15:0] tbit, n;
	rspi_ctrl_t state;
	logic [15:0] notes[$];
	logic [7:0] cfg_q[$];
	logic [15:0] exp_q[$];
	int err_count, num_checks, t0;
	int unsigned seed;

	rspi_port dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
		.spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .radio_irq_o(irq),
		.tbit_cyc_i(tbit), .pa_ramp_o(ramp), .tx_first_bit_o(first),
		.mdm_rx_we_i(mdm_rx_we), .mdm_rx_data_i(mdm_rx_data),
		.mdm_tx_rd_i(mdm_tx_rd), .mdm_tx_data_o(mdm_tx_data),
		.ctrl_state_o(state));
	rspi_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso_w), .got_o(got), .got_stb_o(got_stb));

	// released miso shows a changing pattern, not the last bit
	assign miso_w = miso_oe ? miso : flt;
	always @(posedge clock_i) flt <= (flt === 1'b1) ? 1'b0 : 1'b1;

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic check(input logic [15:0] e, input logic [7:0] act);
		num_checks++;
		if ((act & e[15:8]) !== e[7:0]) begin
			err_count++;
			$display("wrong value at %0t: exp %h got %h", $time, e[7:0], act);
		end
	endtask : check

	task automatic send(input logic [7:0] b[$], input logic [15:0] e[$]);
		foreach (e[i]) notes.push_back(e[i]);
		host_u.xfer(b);
	endtask : send

	task automatic idle(input int k);
		repeat (k) @(posedge clock_i);
	endtask : idle

	task automatic await(ref logic s, output int k);
		k = 0;
		while (s !== 1'b1 && k < 2000) begin
			@(negedge clock_i);
			k++;
		end
		if (s !== 1'b1) begin
			err_count++;
		end
	endtask : await

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// each returned word is judged against the oldest note
	always @(posedge got_stb) begin
		n = notes.pop_front();
		if (n[15:8] !== 8'h00) begin
			check(n, got);
		end
	end

	initial begin
		#400000;
		err_count++;
		final_report();
	end

	initial begin
		reset_n_i = 1'b0;
		tbit = 16'h00c8;
		mdm_rx_we = 1'b0;
		mdm_tx_rd = 1'b0;
		mdm_rx_data = 8'h00;
		seed = $urandom(32'h327cf7bf);
		idle(2);
		reset_n_i <= 1'b1;
		idle(300);
		send('{8'hff, 8'hff}, '{16'hffb1, 16'hffb1});
		// whole retained config ram: irq mask, both pointers, rest random
		cfg_q = '{8'h19, 8'h00};
		exp_q = '{16'hffb1, NA};
		for (int i = 0; i < CFG_BYTES; i++) begin
			exp_q.push_back(NA);
			if (6'(i) == IRQ_MASK1_ADR[5:0]) begin
				cfg_q.push_back(8'h41);
			end else if (6'(i) == TX_BASE_ADR[5:0]
				|| 6'(i) == RX_BASE_ADR[5:0]) begin
				cfg_q.push_back(8'h30);
			end else begin
				cfg_q.push_back(8'($urandom));
			end
		end
		send(cfg_q, exp_q);
		send('{8'h39, 8'h01, 8'hff, 8'hff},
			'{NA, NA, 16'hffb1, 16'hff41});
		send('{8'h39, 8'h24, 8'hff, 8'hff, 8'hff},
			'{NA, NA, NA, 16'hff30, 16'hff30});
		send('{8'h3a, 8'h00, 8'hff, 8'hff},
			'{NA, NA, NA, 16'hff00});
		send('{8'hc2}, '{16'hbfb1});
		idle(200);
		send('{8'hff, 8'hff}, '{16'hfff2, 16'hfff2});
		check(16'hff01, {7'h0, irq});
		send('{8'hc6}, '{16'hfff2});
		idle(200);
		send('{8'h1b, 8'h37, 8'hff}, '{NA, NA, NA});
		send('{8'hff, 8'hff}, '{16'hffb2, 16'hffb2});
		check(16'hff00, {7'h0, irq});
		send('{8'hc3, 8'hc1}, '{16'hffb2, NA});
		idle(200);
		send('{8'hff, 8'hff}, '{16'hbfb3, 16'hbfb3});
		idle(1);
		for (int i = 0; i < 3; i++) begin
			pkt[i] = 8'($urandom);
			mdm_rx_data <= pkt[i];
			mdm_rx_we <= 1'b1;
			idle(1);
			mdm_rx_we <= 1'b0;
			idle(1);
		end
		send('{8'h38, 8'h30, 8'hff, 8'hff, 8'hff, 8'hff},
			'{NA, NA, NA, {8'hff, pkt[0]}, {8'hff, pkt[1]}, {8'hff, pkt[2]}});
		send('{8'hc4}, '{NA});
		await(ramp, t0);
		check({8'hff, pkt[0]}, mdm_tx_data);
		await(first, t0);
		check({8'hff, 8'(DATA_LEAD_CYC + tbit + tbit / 2 - PA_RAMP_CYC)},
			8'(t0));
		@(posedge clock_i);
		mdm_tx_rd <= 1'b1;
		idle(1);
		mdm_tx_rd <= 1'b0;
		idle(2);
		@(negedge clock_i);
		check({8'hff, pkt[1]}, mdm_tx_data);
		// modem control ram is lost in sleep; select low wakes via init
		send('{8'h1b, 8'h07, 8'h3f}, '{NA, NA, NA});
		send('{8'h3b, 8'h07, 8'hff, 8'hff},
			'{NA, NA, NA, 16'hff3f});
		send('{8'hc5}, '{NA});
		idle(200);
		send('{8'hff, 8'hff}, '{16'hbf26, NA});
		idle(300);
		send('{8'h3b, 8'h07, 8'hff, 8'hff},
			'{16'hbfb1, NA, NA, 16'hff00});
		final_report();
	end
endmodule : tb_top
`default_nettype wire
